// ---- logic/sync_port_pkg.sv ----
// constants shared by the synchronous serial port design
package sync_port_pkg;
  // register byte offsets on the bus
  localparam logic [4:0] OFS_RX_CTRL = 5'h00;
  localparam logic [4:0] OFS_RX_HOLD = 5'h04;
  localparam logic [4:0] OFS_TX_HOLD = 5'h08;
  localparam logic [4:0] OFS_TX_CTRL = 5'h0C;
  localparam logic [4:0] OFS_RATE_CTRL = 5'h10;
  localparam logic [4:0] OFS_DIV_HIGH = 5'h14;
  localparam logic [4:0] OFS_DIV_LOW = 5'h18;
  localparam logic [4:0] OFS_IRQ = 5'h1C;
  // receive control/status field positions
  localparam int RX_PORT_EN = 7;
  localparam int RX_NINE_SEL = 6;
  localparam int RX_SINGLE_EN = 5;
  localparam int RX_CONT_EN = 4;
  localparam int RX_FRAME_ERR = 2;
  localparam int RX_OVERRUN = 1;
  localparam int RX_NINTH = 0;
  // transmit control/status field positions
  localparam int TX_CLK_MASTER = 7;
  localparam int TX_NINE_SEL = 6;
  localparam int TX_ENABLE = 5;
  localparam int TX_SYNC_SEL = 4;
  localparam int TX_SHIFT_EMPTY = 1;
  localparam int TX_NINTH = 0;
  // rate control and interrupt register field positions
  localparam int RATE_SIXTEEN = 3;
  localparam int IRQ_RX_FLAG = 0;
  localparam int IRQ_TX_FLAG = 1;
  localparam int IRQ_RX_EN = 4;
  localparam int IRQ_TX_EN = 5;
  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0000;
  localparam logic [3:0] RST_BITCNT = 4'h0;
  // word lengths
  localparam logic [3:0] WORD_BITS_8 = 4'h8;
  localparam logic [3:0] WORD_BITS_9 = 4'h9;
  // shift engine states
  typedef enum logic [1:0] {S_IDLE, S_RX, S_TX} shift_state_t;
endpackage : sync_port_pkg

// ---- logic/sync_serial_port.sv ----
// synchronous half-duplex serial port: master/slave receive and transmit
//
// Function
// - reception starts only after software sets single or continuous receive enable
// - data line is sampled at each falling edge of the shift clock
// - in master mode, single-word enable alone receives one word then stops; a slave ignores it
// - continuous enable keeps receiving words until software clears it
// - both enables set behaves as continuous reception
// - each received word sets receive flag; interrupt only if enabled
// - ninth bit and error flags are readable in receive control register
// - low eight received bits are read from receive holding register
// - clearing continuous enable clears latched reception errors
// - nine-bit words when nine-bit receive select set, else eight-bit
// - clock-source-master cleared makes the port a slave taking the pin clock
// - slave mode keeps shifting on external clock in any low-power state
// - with two words queued the first moves at once to the shift register
// - second word waits in holding register, transmit flag stays clear
// - after first word leaves, second is loaded, then transmit flag sets
// - transmit interrupt, when enabled, wakes the processor from sleep
// - ninth transmit bit set by software before load is shifted ninth
// - transmit flag cannot be cleared by software, only by a holding write
// - read-only shift-empty status bit with no interrupt attached
// - half-duplex: no reception while transmitting and vice versa
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // avalon-mm slave
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // processor state and requests
  input wire logic sleep_i,
  output logic irq_o,
  output logic wake_o,
  // shift clock pin
  input wire logic shift_clock_pin_i,
  output logic shift_clock_pin_o,
  output logic shift_clock_pin_oe_o,
  // data line pin
  input wire logic data_line_pin_i,
  output logic data_line_pin_o,
  output logic data_line_pin_oe_o
);

  // word length in bits for the nine-bit select
  function automatic logic [3:0] word_bits(input logic nine);
    word_bits = nine ? sync_port_pkg::WORD_BITS_9 : sync_port_pkg::WORD_BITS_8;
  endfunction : word_bits

  // count that ends one half period of the master clock
  function automatic logic [15:0] divisor(input logic sixteen, input logic [7:0] hi,
                                          input logic [7:0] lo);
    divisor = sixteen ? {hi, lo} : {8'h00, lo};
  endfunction : divisor

  // register field storage
  logic port_enable_q, nine_bit_rx_select_q, single_word_rx_enable_q, continuous_rx_enable_q;
  logic overrun_error_flag_q, received_ninth_bit_q;
  logic clock_source_master_q, nine_bit_tx_select_q, transmit_enable_q, sync_select_q;
  logic transmit_ninth_bit_q, sixteen_bit_generator_select_q;
  logic [7:0] rate_divisor_high_q, rate_divisor_low_q, receive_holding_q, transmit_holding_q;
  logic rx_interrupt_enable_q, tx_interrupt_enable_q, rx_interrupt_flag_q, tx_interrupt_flag_q;
  logic tx_holding_full_q, tx_holding_ninth_q;
  // bus handshake
  logic waitrequest_q;
  logic [31:0] readdata_q;
  logic bus_wr, bus_rd;
  // synchronisers and clock edges
  logic ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q;
  logic ck_int_q;
  logic [15:0] gen_cnt_q;
  logic fall_ev;
  // shift engine
  sync_port_pkg::shift_state_t state_q;
  logic [8:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic rx_done, tx_done, tx_load, rx_en, port_on, tx_shift_empty;
  logic irq_q, wake_q;

  assign bus_wr = write_i && !waitrequest_q;
  assign bus_rd = read_i && !waitrequest_q;
  assign port_on = port_enable_q && sync_select_q;
  // single-word enable is ignored by a slave; continuous wins when both set
  assign rx_en = port_on && (continuous_rx_enable_q ||
                 (single_word_rx_enable_q && clock_source_master_q));
  // half-duplex: a queued word is not moved while a reception runs
  assign tx_load = port_on && transmit_enable_q && tx_holding_full_q && !bus_wr &&
                   (state_q == sync_port_pkg::S_IDLE);
  assign rx_done = (state_q == sync_port_pkg::S_RX) && fall_ev &&
                   (bit_cnt_q == word_bits(nine_bit_rx_select_q) - 4'h1);
  assign tx_done = (state_q == sync_port_pkg::S_TX) && fall_ev &&
                   (bit_cnt_q == word_bits(nine_bit_tx_select_q) - 4'h1);
  assign tx_shift_empty = (state_q != sync_port_pkg::S_TX);

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then the answer on the second edge
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      waitrequest_q <= 1'b1;
    else if ((read_i || write_i) && waitrequest_q)
      waitrequest_q <= 1'b0;
    else
      waitrequest_q <= 1'b1;
  end

  // read data mux; unmapped offsets read as zero
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      readdata_q <= 32'h0000_0000;
    else if (read_i && waitrequest_q)
    begin
      readdata_q <= 32'h0000_0000;
      case (address_i)
        sync_port_pkg::OFS_RX_CTRL: readdata_q[7:0] <= {port_enable_q, nine_bit_rx_select_q,
          single_word_rx_enable_q, continuous_rx_enable_q, 1'b0, 1'b0,
          overrun_error_flag_q, received_ninth_bit_q};
        sync_port_pkg::OFS_RX_HOLD: readdata_q[7:0] <= receive_holding_q;
        sync_port_pkg::OFS_TX_HOLD: readdata_q[7:0] <= transmit_holding_q;
        sync_port_pkg::OFS_TX_CTRL: readdata_q[7:0] <= {clock_source_master_q,
          nine_bit_tx_select_q, transmit_enable_q, sync_select_q, 2'b00,
          tx_shift_empty, transmit_ninth_bit_q};
        sync_port_pkg::OFS_RATE_CTRL:
          readdata_q[sync_port_pkg::RATE_SIXTEEN] <= sixteen_bit_generator_select_q;
        sync_port_pkg::OFS_DIV_HIGH: readdata_q[7:0] <= rate_divisor_high_q;
        sync_port_pkg::OFS_DIV_LOW: readdata_q[7:0] <= rate_divisor_low_q;
        sync_port_pkg::OFS_IRQ: readdata_q[7:0] <= {2'b00, tx_interrupt_enable_q,
          rx_interrupt_enable_q, 2'b00, tx_interrupt_flag_q, rx_interrupt_flag_q};
        default: readdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // software-written control fields; hardware clears single-word enable after its word
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      {port_enable_q, nine_bit_rx_select_q, single_word_rx_enable_q} <= 3'b000;
      continuous_rx_enable_q <= 1'b0;
      {clock_source_master_q, nine_bit_tx_select_q, transmit_enable_q} <= 3'b000;
      {sync_select_q, transmit_ninth_bit_q, sixteen_bit_generator_select_q} <= 3'b000;
      rate_divisor_high_q <= sync_port_pkg::RST_BYTE;
      rate_divisor_low_q <= sync_port_pkg::RST_BYTE;
      {rx_interrupt_enable_q, tx_interrupt_enable_q} <= 2'b00;
    end
    else
    begin
      if (bus_wr && byteenable_i[0])
      begin
        case (address_i)
          sync_port_pkg::OFS_RX_CTRL:
          begin
            port_enable_q <= writedata_i[sync_port_pkg::RX_PORT_EN];
            nine_bit_rx_select_q <= writedata_i[sync_port_pkg::RX_NINE_SEL];
            single_word_rx_enable_q <= writedata_i[sync_port_pkg::RX_SINGLE_EN];
            continuous_rx_enable_q <= writedata_i[sync_port_pkg::RX_CONT_EN];
          end
          sync_port_pkg::OFS_TX_CTRL:
          begin
            clock_source_master_q <= writedata_i[sync_port_pkg::TX_CLK_MASTER];
            nine_bit_tx_select_q <= writedata_i[sync_port_pkg::TX_NINE_SEL];
            transmit_enable_q <= writedata_i[sync_port_pkg::TX_ENABLE];
            sync_select_q <= writedata_i[sync_port_pkg::TX_SYNC_SEL];
            transmit_ninth_bit_q <= writedata_i[sync_port_pkg::TX_NINTH];
          end
          sync_port_pkg::OFS_RATE_CTRL:
            sixteen_bit_generator_select_q <= writedata_i[sync_port_pkg::RATE_SIXTEEN];
          sync_port_pkg::OFS_DIV_HIGH: rate_divisor_high_q <= writedata_i[7:0];
          sync_port_pkg::OFS_DIV_LOW: rate_divisor_low_q <= writedata_i[7:0];
          sync_port_pkg::OFS_IRQ:
          begin
            rx_interrupt_enable_q <= writedata_i[sync_port_pkg::IRQ_RX_EN];
            tx_interrupt_enable_q <= writedata_i[sync_port_pkg::IRQ_TX_EN];
          end
          default: ;
        endcase
      end
      // a finished single word ends the request; hardware beats a same-edge write
      if (rx_done && !continuous_rx_enable_q)
        single_word_rx_enable_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      {ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q} <= 5'b00000;
    else
    begin
      ck_s1_q <= shift_clock_pin_i;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      dt_s1_q <= data_line_pin_i;
      dt_s2_q <= dt_s1_q;
    end
  end

  // master clock generator, runs only while a word is being shifted
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i || state_q == sync_port_pkg::S_IDLE || !clock_source_master_q)
    begin
      gen_cnt_q <= sync_port_pkg::RST_DIV;
      ck_int_q <= 1'b0;
    end
    else if (gen_cnt_q == divisor(sixteen_bit_generator_select_q, rate_divisor_high_q,
             rate_divisor_low_q))
    begin
      gen_cnt_q <= sync_port_pkg::RST_DIV;
      ck_int_q <= !ck_int_q;
    end
    else
      gen_cnt_q <= gen_cnt_q + 16'h0001;
  end

  // edge events: own divider in master, pin clock in slave
  // slave edges need no local clock division, so they keep working in low power
  // limitation: in master mode the synchronised line lags the clock rise by about three
  // clocks, so a divisor below 3 is too fast for a peer that changes data on the rise
  always_comb
  begin
    if (clock_source_master_q)
      fall_ev = (state_q != sync_port_pkg::S_IDLE) && ck_int_q &&
        (gen_cnt_q == divisor(sixteen_bit_generator_select_q, rate_divisor_high_q,
         rate_divisor_low_q));
    else
      fall_ev = !ck_s2_q && ck_s3_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // shift engine: one word at a time, either direction, never both
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i || !port_on)
    begin
      state_q <= sync_port_pkg::S_IDLE;
      shift_q <= 9'h000;
      bit_cnt_q <= sync_port_pkg::RST_BITCNT;
    end
    else
    begin
      case (state_q)
        sync_port_pkg::S_IDLE:
        begin
          bit_cnt_q <= sync_port_pkg::RST_BITCNT;
          if (tx_load)
          begin
            state_q <= sync_port_pkg::S_TX;
            shift_q <= {tx_holding_ninth_q, transmit_holding_q};
          end
          else if (rx_en && !tx_holding_full_q)
            state_q <= sync_port_pkg::S_RX;
        end
        sync_port_pkg::S_RX:
        begin
          if (fall_ev)
          begin
            // lsb first: the new bit enters at the top of the active width
            if (nine_bit_rx_select_q)
              shift_q <= {dt_s2_q, shift_q[8:1]};
            else
              shift_q <= {1'b0, dt_s2_q, shift_q[7:1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (rx_done || !rx_en)
            state_q <= sync_port_pkg::S_IDLE;
        end
        sync_port_pkg::S_TX:
        begin
          if (fall_ev)
          begin
            shift_q <= {1'b0, shift_q[8:1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (tx_done)
            state_q <= sync_port_pkg::S_IDLE;
        end
        default: state_q <= sync_port_pkg::S_IDLE;
      endcase
    end
  end

  // received word, ninth bit and overrun; errors live only while continuous is on
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      receive_holding_q <= sync_port_pkg::RST_BYTE;
      received_ninth_bit_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
      rx_interrupt_flag_q <= 1'b0;
    end
    else
    begin
      if (!continuous_rx_enable_q)
        overrun_error_flag_q <= 1'b0;
      if (bus_rd && address_i == sync_port_pkg::OFS_RX_HOLD)
        rx_interrupt_flag_q <= 1'b0;
      // a word landing on the clearing edge still sets the flag
      if (rx_done)
      begin
        if (rx_interrupt_flag_q && !(bus_rd && address_i == sync_port_pkg::OFS_RX_HOLD))
          overrun_error_flag_q <= continuous_rx_enable_q;
        else
        begin
          receive_holding_q <= nine_bit_rx_select_q ? shift_q[8:1] : {dt_s2_q, shift_q[7:1]};
          received_ninth_bit_q <= nine_bit_rx_select_q ? dt_s2_q : 1'b0;
          rx_interrupt_flag_q <= 1'b1;
        end
      end
    end
  end

  // transmit holding register and its flag; only a holding write can clear the flag
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      transmit_holding_q <= sync_port_pkg::RST_BYTE;
      tx_holding_ninth_q <= 1'b0;
      tx_holding_full_q <= 1'b0;
      tx_interrupt_flag_q <= 1'b1;
    end
    else if (bus_wr && byteenable_i[0] && address_i == sync_port_pkg::OFS_TX_HOLD)
    begin
      transmit_holding_q <= writedata_i[7:0];
      tx_holding_ninth_q <= transmit_ninth_bit_q;
      tx_holding_full_q <= 1'b1;
      tx_interrupt_flag_q <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_holding_full_q <= 1'b0;
      tx_interrupt_flag_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drive, interrupt request and wake-up
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      {shift_clock_pin_o, shift_clock_pin_oe_o, data_line_pin_o, data_line_pin_oe_o} <= 4'h0;
      {irq_q, wake_q} <= 2'b00;
    end
    else
    begin
      shift_clock_pin_o <= ck_int_q;
      shift_clock_pin_oe_o <= port_on && clock_source_master_q;
      data_line_pin_oe_o <= (state_q == sync_port_pkg::S_TX);
      data_line_pin_o <= shift_q[0];
      irq_q <= (rx_interrupt_flag_q && rx_interrupt_enable_q) ||
               (tx_interrupt_flag_q && tx_interrupt_enable_q && transmit_enable_q);
      wake_q <= sleep_i && ((rx_interrupt_flag_q && rx_interrupt_enable_q) ||
               (tx_interrupt_flag_q && tx_interrupt_enable_q && transmit_enable_q));
    end
  end

  assign irq_o = irq_q;
  assign wake_o = wake_q;
  assign readdata_o = readdata_q;
  assign waitrequest_o = waitrequest_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_no_rx_without_enable;
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_q == sync_port_pkg::S_IDLE && !rx_en) |=> (state_q != sync_port_pkg::S_RX);
  endproperty
  a_no_rx_without_enable: assert property (p_no_rx_without_enable)
    else $error("reception started with no receive enable");

  property p_single_stops;
    @(posedge mclk_i) disable iff (!rstn_i)
    (rx_done && !continuous_rx_enable_q) |=> !single_word_rx_enable_q ##1
      (state_q != sync_port_pkg::S_RX || continuous_rx_enable_q);
  endproperty
  a_single_stops: assert property (p_single_stops)
    else $error("single-word reception did not stop");

  property p_cont_goes_on;
    @(posedge mclk_i) disable iff (!rstn_i)
    (rx_done && continuous_rx_enable_q && !tx_holding_full_q) |=>
      ##1 (state_q == sync_port_pkg::S_RX || !continuous_rx_enable_q || tx_holding_full_q);
  endproperty
  a_cont_goes_on: assert property (p_cont_goes_on)
    else $error("continuous reception did not resume");

  property p_rx_flag_irq;
    @(posedge mclk_i) disable iff (!rstn_i)
    (rx_done && !rx_interrupt_flag_q && rx_interrupt_enable_q) |=> rx_interrupt_flag_q ##1 irq_o;
  endproperty
  a_rx_flag_irq: assert property (p_rx_flag_irq)
    else $error("received word did not raise flag and request");

  property p_err_cleared;
    @(posedge mclk_i) disable iff (!rstn_i)
    $fell(continuous_rx_enable_q) |=> !overrun_error_flag_q;
  endproperty
  a_err_cleared: assert property (p_err_cleared)
    else $error("overrun survived clearing continuous enable");

  property p_half_duplex;
    @(posedge mclk_i) disable iff (!rstn_i)
    data_line_pin_oe_o |-> $past(state_q) == sync_port_pkg::S_TX;
  endproperty
  a_half_duplex: assert property (p_half_duplex)
    else $error("data line driven outside transmission");

  property p_slave_no_clock;
    @(posedge mclk_i) disable iff (!rstn_i)
    !clock_source_master_q |=> !shift_clock_pin_oe_o;
  endproperty
  a_slave_no_clock: assert property (p_slave_no_clock)
    else $error("slave drove the shift clock");

  property p_tx_flag_after_load;
    @(posedge mclk_i) disable iff (!rstn_i)
    tx_load |=> (tx_interrupt_flag_q && state_q == sync_port_pkg::S_TX && !tx_shift_empty);
  endproperty
  a_tx_flag_after_load: assert property (p_tx_flag_after_load)
    else $error("transmit flag not set on shift register load");

  property p_tx_flag_write_only;
    @(posedge mclk_i) disable iff (!rstn_i)
    (tx_interrupt_flag_q && !(bus_wr && address_i == sync_port_pkg::OFS_TX_HOLD)) |=>
      tx_interrupt_flag_q;
  endproperty
  a_tx_flag_write_only: assert property (p_tx_flag_write_only)
    else $error("transmit flag dropped without a holding write");

  c_rx_word: cover property (@(posedge mclk_i) disable iff (!rstn_i) rx_done);
  c_tx_back_to_back: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    tx_done ##[1:4] tx_load);
  c_overrun: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(overrun_error_flag_q));

endmodule : sync_serial_port
`default_nettype wire

// ---- verification/serial_peer.sv ----
// behavioural far-side peer on the shift clock and data lines
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  // link lines
  input wire logic ck_i,
  input wire logic dt_i,
  output logic ck_o,
  output logic dt_o,
  // bench control
  input wire logic go_i,
  input wire logic slave_i,
  input wire logic [8:0] word_i,
  output logic [7:0] cap_o
);
  int idx;
  initial
  begin
    ck_o = 1'b0;
    dt_o = 1'b1;
    cap_o = 8'h00;
    idx = 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // new frame restarts the bit index; as clock owner make eight 200 ns cycles
  // off the system clock grid, then let the clock stand low
  always @(posedge go_i)
  begin
    idx = 0;
    #7;
    if (slave_i)
      repeat (8)
      begin
        #100 ck_o = 1'b1;
        #100 ck_o = 1'b0;
      end
  end
  // next bit goes out after the rise so it is steady at the fall; lsb first
  // a nine-bit index wraps so continuous nine-bit frames repeat the word
  always @(posedge ck_i)
  begin
    dt_o <= word_i[idx];
    idx = (idx == 8) ? 0 : idx + 1;
    cap_o <= {dt_i, cap_o[7:1]};
  end
endmodule : serial_peer
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the synchronous serial port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_i, rstn_i, read_i, write_i, sleep_i, waitrequest_o, irq_o, wake_o;
  logic shift_clock_pin_o, shift_clock_pin_oe_o, data_line_pin_o, data_line_pin_oe_o;
  logic go, slave, peer_ck, peer_dt, ck, dt;
  logic [4:0] address_i;
  logic [31:0] writedata_i, readdata_o;
  logic [8:0] word;
  logic [7:0] cap, q;
  int error_cnt, checks_done;
  // the wire levels follow whoever enables its driver
  assign ck = shift_clock_pin_oe_o ? shift_clock_pin_o : peer_ck;
  assign dt = data_line_pin_oe_o ? data_line_pin_o : peer_dt;
  sync_serial_port i_sync_serial_port (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .byteenable_i(4'h1),
    .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .sleep_i(sleep_i), .irq_o(irq_o), .wake_o(wake_o), .shift_clock_pin_i(ck),
    .shift_clock_pin_o(shift_clock_pin_o), .shift_clock_pin_oe_o(shift_clock_pin_oe_o),
    .data_line_pin_i(dt), .data_line_pin_o(data_line_pin_o),
    .data_line_pin_oe_o(data_line_pin_oe_o));
  serial_peer i_serial_peer (.ck_i(ck), .dt_i(dt), .ck_o(peer_ck), .dt_o(peer_dt),
    .go_i(go), .slave_i(slave), .word_i(word), .cap_o(cap));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz system clock
  initial mclk_i = 1'b0;
  always #12.5 mclk_i = ~mclk_i;
  // one bus access; request held until waitrequest is seen low, only the watchdog ends a hang
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge mclk_i);
    address_i <= a;
    writedata_i <= {24'h000000, d};
    write_i <= w;
    read_i <= ~w;
    do
    begin
      @(posedge mclk_i);
    end while (waitrequest_o !== 1'b0);
    r = readdata_o[7:0];
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask : acc
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // bounded wait for irq (0) or wake (1); a registered level lags a clear
  task automatic wt(input bit sel);
    int n;
    n = 0;
    repeat (2) @(posedge mclk_i);
    while ((sel ? wake_o : irq_o) !== 1'b1 && n < 3000)
    begin
      @(posedge mclk_i);
      n++;
    end
    chk({7'h00, sel ? wake_o : irq_o}, 8'h01);
  endtask : wt
  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the several hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    print_verdict();
  end
  // test sequence
  initial
  begin
    rstn_i = 1'b0;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = 5'h00;
    writedata_i = 32'h00000000;
    sleep_i = 1'b0;
    go = 1'b0;
    slave = 1'b0;
    word = 9'h000;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    acc(1'b0, sync_port_pkg::OFS_RX_CTRL, 8'h00, q);
    chk(q, 8'h00);
    acc(1'b0, sync_port_pkg::OFS_IRQ, 8'h00, q);
    chk(q, 8'h02);
    acc(1'b0, sync_port_pkg::OFS_TX_CTRL, 8'h00, q);
    chk(q, 8'h02);
    acc(1'b0, 5'h02, 8'h00, q);
    chk(q, 8'h00);
    // master single-word reception, divisor 4: slow enough for the line's synchroniser
    acc(1'b1, sync_port_pkg::OFS_DIV_LOW, 8'h04, q);
    acc(1'b1, sync_port_pkg::OFS_TX_CTRL, 8'h90, q);
    acc(1'b1, sync_port_pkg::OFS_IRQ, 8'h10, q);
    word = 9'h0A5;
    go <= 1'b1;
    acc(1'b1, sync_port_pkg::OFS_RX_CTRL, 8'h80, q);
    acc(1'b1, sync_port_pkg::OFS_RX_CTRL, 8'hA0, q);
    wt(1'b0);
    acc(1'b0, sync_port_pkg::OFS_RX_CTRL, 8'h00, q);
    chk(q, 8'h80);
    acc(1'b0, sync_port_pkg::OFS_RX_HOLD, 8'h00, q);
    chk(q, 8'hA5);
    repeat (8)
    begin
      @(posedge mclk_i);
      chk({7'h00, shift_clock_pin_o}, 8'h00);
    end
    go <= 1'b0;
    // continuous nine-bit reception with both enables set; a clock passes so go rises again
    @(posedge mclk_i);
    word = 9'h13C;
    go <= 1'b1;
    acc(1'b1, sync_port_pkg::OFS_RX_CTRL, 8'hF0, q);
    wt(1'b0);
    acc(1'b0, sync_port_pkg::OFS_RX_CTRL, 8'h00, q);
    chk(q & 8'h01, 8'h01);
    acc(1'b0, sync_port_pkg::OFS_RX_HOLD, 8'h00, q);
    chk(q, 8'h3C);
    wt(1'b0);
    acc(1'b0, sync_port_pkg::OFS_RX_HOLD, 8'h00, q);
    chk(q, 8'h3C);
    // leave two more words unread so the second one overruns
    repeat (250) @(posedge mclk_i);
    acc(1'b0, sync_port_pkg::OFS_RX_CTRL, 8'h00, q);
    chk(q & 8'h02, 8'h02);
    acc(1'b1, sync_port_pkg::OFS_RX_CTRL, 8'h80, q);
    acc(1'b0, sync_port_pkg::OFS_RX_CTRL, 8'h00, q);
    chk(q & 8'hFE, 8'h80);
    go <= 1'b0;
    // slave transmission of two words queued before sleep
    acc(1'b1, sync_port_pkg::OFS_TX_CTRL, 8'h30, q);
    acc(1'b1, sync_port_pkg::OFS_IRQ, 8'h20, q);
    acc(1'b1, sync_port_pkg::OFS_TX_HOLD, 8'h5A, q);
    acc(1'b1, sync_port_pkg::OFS_TX_HOLD, 8'hC3, q);
    sleep_i <= 1'b1;
    acc(1'b0, sync_port_pkg::OFS_IRQ, 8'h00, q);
    chk(q & 8'h02, 8'h00);
    acc(1'b0, sync_port_pkg::OFS_TX_HOLD, 8'h00, q);
    chk(q, 8'hC3);
    slave <= 1'b1;
    go <= 1'b1;
    wt(1'b1);
    chk(cap, 8'h5A);
    go <= 1'b0;
    @(posedge mclk_i);
    go <= 1'b1;
    // the peer's eight 200 ns cycles take 64 system clocks
    repeat (80) @(posedge mclk_i);
    chk(cap, 8'hC3);
    acc(1'b0, sync_port_pkg::OFS_TX_CTRL, 8'h00, q);
    chk(q & 8'h02, 8'h02);
    acc(1'b1, sync_port_pkg::OFS_IRQ, 8'h20, q);
    acc(1'b0, sync_port_pkg::OFS_IRQ, 8'h00, q);
    chk(q & 8'h02, 8'h02);
    sleep_i <= 1'b0;
    print_verdict();
  end
endmodule : tb
`default_nettype wire
